/* verilog/wdg_top.sv */
// Watchdog timer with keyed enable, keyed reset guard and reset-cause flags.
// Assumes an APB master on mclk, CPU instruction strobes on mclk, and the slow
// oscillator and brownout detector arriving as asynchronous pins.
`timescale 1ns/100ps
`default_nettype none

module wdg_top #(
  parameter int GUARD_DELAY = wdg_pkg::GUARD_DELAY_TICKS  // Guard delay in slow ticks.
) (
  // Clock and synchronous reset.
  input  wire logic        mclk,
  input  wire logic        reset,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Asynchronous pins.
  input  wire logic        slow_internal_osc,
  input  wire logic        brownout_detect,
  // CPU strobes and state.
  input  wire logic        kick_instruction,
  input  wire logic        halt_instruction,
  input  wire logic        sleep_mode,
  // Reset requests towards the core.
  output logic             device_reset_q,
  output logic             pc_sp_reset_q,
  output logic             pc_zero_q
);

  // State of the delayed-reset sequencer.
  typedef enum logic [0:0] {
    WDG_IDLE    = 1'b0,
    WDG_PENDING = 1'b1
  } wdg_guard_state_t;

  // Returns the last count value for a period select code.
  function automatic logic [wdg_pkg::CNT_W-1:0] last_count(input logic [2:0] sel);
    case (sel)
      3'h0:    last_count = wdg_pkg::LAST_2P8;
      3'h1:    last_count = wdg_pkg::LAST_2P10;
      3'h2:    last_count = wdg_pkg::LAST_2P12;
      3'h3:    last_count = wdg_pkg::LAST_2P14;
      3'h4:    last_count = wdg_pkg::LAST_2P15;
      3'h5:    last_count = wdg_pkg::LAST_2P16;
      3'h6:    last_count = wdg_pkg::LAST_2P17;
      default: last_count = wdg_pkg::LAST_2P18;
    endcase
  endfunction

  // Tells whether an enable key is one of the two legal codes.
  function automatic logic key_legal(input logic [4:0] key);
    key_legal = (key == wdg_pkg::KEY_ENABLE) || (key == wdg_pkg::KEY_DISABLE);
  endfunction

  // Registers visible to software.
  logic [7:0]  dog_control_q;              // Enable key and period select.
  logic [7:0]  reset_guard_q;              // Guard pattern.
  logic [7:0]  level_ctrl_q;               // Level control pattern.
  logic [3:0]  cause_flags_q;              // Sticky reset causes.
  logic        expiry_flag_q;              // Watchdog time-out seen.
  logic        powerdown_flag_q;           // Halt executed since last kick.

  // Internal state.
  logic [2:0]  osc_sync_q;                 // Slow oscillator synchroniser and edge stage.
  logic [1:0]  bo_sync_q;                  // Brownout synchroniser.
  logic [wdg_pkg::CNT_W-1:0] dog_count_q;  // Watchdog count in slow ticks.
  wdg_guard_state_t guard_state_q;         // Delayed-reset sequencer state.
  logic [15:0] delay_count_q;              // Ticks spent waiting for the guard delay.
  logic [2:0]  pend_cause_q;               // Faults latched for the pending reset.
  logic [31:0] prdata_q;                   // Read data captured in the setup cycle.
  logic        pslverr_q;                  // Error answer captured in the setup cycle.

  // Decoded helpers.
  logic        slow_tick;                  // One mclk pulse per slow oscillator rise.
  logic        dog_enabled;                // Watchdog counting allowed.
  logic        key_fault;                  // Enable key holds an illegal code.
  logic        guard_fault;                // Guard holds an illegal pattern.
  logic        level_fault;                // Level register holds an illegal pattern.
  logic        wr_access;                  // Write completing this edge.
  logic        wr_bad_key;                 // Write of an illegal enable key.
  logic        overflow;                   // Count reaches its period this tick.
  logic        fire;                       // Delayed reset releases this edge.
  logic        self_reset;                 // Block-initiated full reset this edge.
  logic [15:0] delay_last;                 // Last tick of the guard delay.

  assign delay_last  = 16'(GUARD_DELAY - 1);
  assign slow_tick   = osc_sync_q[1] & ~osc_sync_q[2];                           // R1
  assign dog_enabled = dog_control_q[wdg_pkg::KEY_MSB:wdg_pkg::KEY_LSB]
                       == wdg_pkg::KEY_ENABLE;                                   // R3
  assign key_fault   = ~key_legal(dog_control_q[wdg_pkg::KEY_MSB:wdg_pkg::KEY_LSB]); // R4
  assign guard_fault = (reset_guard_q != wdg_pkg::GUARD_OK_A)
                       && (reset_guard_q != wdg_pkg::GUARD_OK_B);                // R10
  assign level_fault = (level_ctrl_q != wdg_pkg::LEVEL_OK_A)
                       && (level_ctrl_q != wdg_pkg::LEVEL_OK_B);                 // R16
  assign wr_access   = psel & penable & pwrite;
  assign wr_bad_key  = wr_access && (paddr == wdg_pkg::ADDR_DOG_CONTROL)
                       && !key_legal(pwdata[wdg_pkg::KEY_MSB:wdg_pkg::KEY_LSB]);
  assign overflow    = slow_tick && dog_enabled
                       && (dog_count_q == last_count(dog_control_q[wdg_pkg::SEL_MSB:0])); // R2
  assign fire        = (guard_state_q == WDG_PENDING) && slow_tick
                       && (delay_count_q == delay_last);                         // R17
  assign self_reset  = fire || (overflow && !sleep_mode);

  // The slave never inserts wait states.
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // Two-stage synchronisers; the third oscillator stage only feeds edge detection.
  always_ff @(posedge mclk) begin
    if (reset) begin
      osc_sync_q <= 3'h0;
      bo_sync_q  <= 2'h0;
    end else begin
      osc_sync_q <= {osc_sync_q[1:0], slow_internal_osc};
      bo_sync_q  <= {bo_sync_q[0], brownout_detect};
    end
  end

  // Dog control register; a block-initiated full reset restores its power-on value.
  always_ff @(posedge mclk) begin
    if (reset || self_reset) begin
      dog_control_q <= wdg_pkg::DOG_CONTROL_POR; // R5
    end else if (wr_access && paddr == wdg_pkg::ADDR_DOG_CONTROL) begin
      dog_control_q <= pwdata[7:0];
    end
  end

  // Guard and level registers, restored the same way.
  always_ff @(posedge mclk) begin
    if (reset || self_reset) begin
      reset_guard_q <= wdg_pkg::RESET_GUARD_POR; // R11
      level_ctrl_q  <= wdg_pkg::LEVEL_CTRL_POR;
    end else if (wr_access) begin
      if (paddr == wdg_pkg::ADDR_RESET_GUARD) begin
        reset_guard_q <= pwdata[7:0];
      end
      if (paddr == wdg_pkg::ADDR_LEVEL_CTRL) begin
        level_ctrl_q <= pwdata[7:0];
      end
    end
  end

  // Watchdog counter: runs on slow ticks only, cleared by kick, halt or a bad key write.
  always_ff @(posedge mclk) begin
    if (reset || self_reset) begin
      dog_count_q <= '0;
    end else if (kick_instruction || halt_instruction || wr_bad_key) begin
      dog_count_q <= '0; // R8 R15
    end else if (overflow) begin
      dog_count_q <= '0;
    end else if (slow_tick && dog_enabled) begin
      dog_count_q <= dog_count_q + 1'b1; // R1
    end
  end

  // Delayed-reset sequencer: any illegal pattern starts the delay, which then runs out.
  always_ff @(posedge mclk) begin
    if (reset) begin
      guard_state_q <= WDG_IDLE;
      delay_count_q <= 16'h0000;
      pend_cause_q  <= 3'h0;
    end else begin
      case (guard_state_q)
        WDG_IDLE: begin
          // Start waiting as soon as any keyed register goes bad.
          if (key_fault || guard_fault || level_fault) begin
            guard_state_q <= WDG_PENDING;
            delay_count_q <= 16'h0000;
            pend_cause_q  <= {guard_fault, level_fault, key_fault}; // R4 R10 R16
          end
        end
        WDG_PENDING: begin
          // Collect further causes and release after the delay.
          pend_cause_q <= pend_cause_q | {guard_fault, level_fault, key_fault};
          if (fire) begin
            guard_state_q <= WDG_IDLE;
            delay_count_q <= 16'h0000;
            pend_cause_q  <= 3'h0;
          end else if (slow_tick) begin
            delay_count_q <= delay_count_q + 16'h0001; // R17
          end
        end
        default: begin
          guard_state_q <= WDG_IDLE;
        end
      endcase
    end
  end

  // Flags kept through a software write: a written 0 clears, a written 1 keeps.
  logic [3:0]  cause_keep;                 // Flags that survive this edge's write.
  logic [3:0]  cause_set;                  // Causes raised at this edge.
  always_comb begin
    cause_keep = cause_flags_q;
    if (wr_access && paddr == wdg_pkg::ADDR_CAUSE_FLAGS) begin
      cause_keep = cause_flags_q & pwdata[3:0]; // R9 R12
    end
  end

  // Causes raised together with the delayed reset, plus the brownout level.
  always_comb begin
    cause_set                          = 4'h0;
    cause_set[wdg_pkg::FLAG_DOG_KEY]   = fire & pend_cause_q[0]; // R4 R9
    cause_set[wdg_pkg::FLAG_LEVEL_REG] = fire & pend_cause_q[1]; // R16
    cause_set[wdg_pkg::FLAG_BROWNOUT]  = bo_sync_q[1];
    cause_set[wdg_pkg::FLAG_GUARD_REG] = fire & pend_cause_q[2]; // R12
  end

  // Reset-cause flags; a new cause wins over a software clear in the same cycle.
  always_ff @(posedge mclk) begin
    if (reset) begin
      cause_flags_q <= 4'h0;
    end else begin
      cause_flags_q <= cause_keep | cause_set;
    end
  end

  // Expiry and power-down flags of the CPU status word.
  always_ff @(posedge mclk) begin
    if (reset) begin
      expiry_flag_q    <= 1'b0;
      powerdown_flag_q <= 1'b0;
    end else begin
      // An overflow wins over a kick or halt clearing the expiry flag.
      if (overflow) begin
        expiry_flag_q <= 1'b1; // R6 R7
      end else if (kick_instruction || halt_instruction) begin
        expiry_flag_q <= 1'b0;
      end
      // A halt sets the power-down flag even when an overflow lands with it.
      if (halt_instruction) begin
        powerdown_flag_q <= 1'b1; // R15
      end else if (kick_instruction) begin
        powerdown_flag_q <= 1'b0;
      end
    end
  end

  // Reset request outputs, one mclk pulse each.
  always_ff @(posedge mclk) begin
    if (reset) begin
      device_reset_q <= 1'b0;
      pc_sp_reset_q  <= 1'b0;
    end else begin
      device_reset_q <= self_reset;           // R4 R6 R10
      pc_sp_reset_q  <= overflow & sleep_mode; // R7
    end
  end

  // Program counter zero request: held through power-on reset and on any block reset.
  always_ff @(posedge mclk) begin
    if (reset) begin
      pc_zero_q <= 1'b1; // R14
    end else begin
      pc_zero_q <= self_reset || (overflow && sleep_mode);
    end
  end

  // APB read path and error answer, captured in the setup cycle.
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      case (paddr)
        wdg_pkg::ADDR_DOG_CONTROL: prdata_q[7:0] <= dog_control_q;
        wdg_pkg::ADDR_CAUSE_FLAGS: prdata_q[3:0] <= cause_flags_q; // R13
        wdg_pkg::ADDR_RESET_GUARD: prdata_q[7:0] <= reset_guard_q;
        wdg_pkg::ADDR_LEVEL_CTRL:  prdata_q[7:0] <= level_ctrl_q;
        wdg_pkg::ADDR_DOG_STATUS: begin
          prdata_q[wdg_pkg::STAT_EXPIRY]    <= expiry_flag_q;
          prdata_q[wdg_pkg::STAT_POWERDOWN] <= powerdown_flag_q;
          prdata_q[wdg_pkg::STAT_ENABLED]   <= dog_enabled;
        end
        default: pslverr_q <= 1'b1;
      endcase
    end
  end

endmodule

`default_nettype wire

/* pkg/wdg_pkg.sv */
// Constants shared by the watchdog with reset guards: register map, field layout,
// power-on values, legal key codes and time-out lengths.
// Assumes a 32-bit APB register bus and a slow oscillator sampled on mclk.
// Function
// R1 - Count only on slow oscillator ticks
// R2 - Period select picks 2^8 to 2^18 ticks
// R3 - Key 10101B disables, 01010B enables watchdog
// R4 - Other key: delayed reset, set key fault
// R5 - Enable key powers up as 01010B
// R6 - Normal overflow: full reset, set expiry flag
// R7 - Sleep overflow: expiry flag, reset PC, SP
// R8 - Illegal key, kick, halt clear count
// R9 - Key fault flag bit 0, software clears
// R10 - Guard 55h or AAh inert, else reset
// R11 - Guard powers up as 01010101
// R12 - Guard fault flag bit 3, software clears
// R13 - Cause flags bits 7 to 4 read zero
// R14 - Power-on reset forces program counter zero
// R15 - Halt clears count, running only if enabled
// R16 - Undefined level register sets its fault flag
// R17 - Guard delay is a parameter in ticks
package wdg_pkg;

  // Byte addresses of the registers on the APB bus.
  localparam logic [7:0] ADDR_DOG_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_CAUSE_FLAGS  = 8'h04;
  localparam logic [7:0] ADDR_RESET_GUARD  = 8'h08;
  localparam logic [7:0] ADDR_LEVEL_CTRL   = 8'h0c;
  localparam logic [7:0] ADDR_DOG_STATUS   = 8'h10;

  // Power-on values of the control registers.
  localparam logic [7:0] DOG_CONTROL_POR   = 8'h53;
  localparam logic [7:0] RESET_GUARD_POR   = 8'h55;
  localparam logic [7:0] LEVEL_CTRL_POR    = 8'h5a;

  // Field positions inside dog_control.
  localparam int KEY_LSB = 3;
  localparam int KEY_MSB = 7;
  localparam int SEL_MSB = 2;

  // Legal codes of the keyed fields.
  localparam logic [4:0] KEY_DISABLE       = 5'h15;
  localparam logic [4:0] KEY_ENABLE        = 5'h0a;
  localparam logic [7:0] GUARD_OK_A        = 8'h55;
  localparam logic [7:0] GUARD_OK_B        = 8'haa;
  localparam logic [7:0] LEVEL_OK_A        = 8'h5a;
  localparam logic [7:0] LEVEL_OK_B        = 8'ha5;

  // Bit positions inside reset_cause_flags and the status register.
  localparam int FLAG_DOG_KEY   = 0;
  localparam int FLAG_LEVEL_REG = 1;
  localparam int FLAG_BROWNOUT  = 2;
  localparam int FLAG_GUARD_REG = 3;
  localparam int STAT_EXPIRY    = 0;
  localparam int STAT_POWERDOWN = 1;
  localparam int STAT_ENABLED   = 2;

  // Last count value of each time-out, one less than the period in ticks.
  localparam int CNT_W = 18;
  localparam logic [CNT_W-1:0] LAST_2P8  = 18'h000ff;
  localparam logic [CNT_W-1:0] LAST_2P10 = 18'h003ff;
  localparam logic [CNT_W-1:0] LAST_2P12 = 18'h00fff;
  localparam logic [CNT_W-1:0] LAST_2P14 = 18'h03fff;
  localparam logic [CNT_W-1:0] LAST_2P15 = 18'h07fff;
  localparam logic [CNT_W-1:0] LAST_2P16 = 18'h0ffff;
  localparam logic [CNT_W-1:0] LAST_2P17 = 18'h1ffff;
  localparam logic [CNT_W-1:0] LAST_2P18 = 18'h3ffff;

  // Nominal slow oscillator rate in kHz, for reference of the tick period.
  localparam int SLOW_OSC_KHZ = 32;

  // Default guard reset delay in slow oscillator ticks.
  localparam int GUARD_DELAY_TICKS = 4;

endpackage

/* bench/wdg_chk.sv */
// Checker for the watchdog top: reset pulses, tick source and bus answers.
// Assumes it is bound to every wdg_top instance.
`timescale 1ns/100ps
`default_nettype none
module wdg_chk (
  // Clock, reset and bus.
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Pins and reset requests.
  input wire logic        slow_internal_osc,
  input wire logic        sleep_mode,
  input wire logic        device_reset_q,
  input wire logic        pc_sp_reset_q,
  input wire logic        pc_zero_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic [3:0] since_q;  // Cycles since the oscillator pin last rose.
  logic       osc_q;    // Oscillator pin one cycle late.
  logic       setup;    // A setup cycle is on the bus.
  assign setup = psel && !penable;
  // A device or wake reset request must follow a slow tick closely.
  always_ff @(posedge mclk) begin
    osc_q <= slow_internal_osc;
    if (reset) since_q <= 4'hf;
    else if (slow_internal_osc && !osc_q) since_q <= 4'h0;
    else if (since_q != 4'hf) since_q <= since_q + 4'h1;
  end
  a_full_single: assert property (device_reset_q |=> !device_reset_q)
    else $error("Device reset request is not a single pulse.");
  a_full_pc_zero: assert property (device_reset_q |-> pc_zero_q)
    else $error("Program counter not zeroed with device reset.");
  a_wake_pc_zero: assert property (pc_sp_reset_q |-> pc_zero_q && !device_reset_q)
    else $error("Wake reset is wrong.");
  a_wake_in_sleep: assert property (pc_sp_reset_q |-> $past(sleep_mode))
    else $error("Wake reset outside sleep.");
  a_tick_source: assert property ((device_reset_q || pc_sp_reset_q) |-> since_q <= 4'h8)
    else $error("Reset request not tied to a slow tick.");
  a_por_pc_zero: assert property (disable iff (1'b0) reset |=> pc_zero_q)
    else $error("Program counter not zeroed by reset.");
  a_cause_top_zero: assert property (setup && !pwrite && paddr == wdg_pkg::ADDR_CAUSE_FLAGS
    |=> prdata[31:4] == 28'h0)
    else $error("Cause flags upper bits not zero.");
  a_unmapped_err: assert property (setup && paddr > wdg_pkg::ADDR_DOG_STATUS
    |=> pslverr && prdata == 32'h0)
    else $error("Unmapped access not refused.");
  a_ready_high: assert property (pready)
    else $error("Ready dropped.");
  cover property (device_reset_q);
  cover property (pc_sp_reset_q);
  cover property (setup && paddr == 8'h04);
endmodule
bind wdg_top wdg_chk chk_u (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .slow_internal_osc(slow_internal_osc), .sleep_mode(sleep_mode),
  .device_reset_q(device_reset_q), .pc_sp_reset_q(pc_sp_reset_q), .pc_zero_q(pc_zero_q));
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the watchdog: APB tasks, slow ticks and reset counts.
// Assumes a 250 MHz mclk and a slow tick made of 8 mclk cycles.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int GD = 2;  // Shortened guard delay in slow ticks.
  logic mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, osc = 1'b0, kick = 1'b0, halt = 1'b0, sleep = 1'b0;
  logic dev_rst, wake_rst, pc_zero;
  int errors = 0, samples_checked = 0, cycles = 0, rst_cnt = 0, wake_cnt = 0, n = 0;
  always #2 mclk = ~mclk;
  wdg_top #(.GUARD_DELAY(GD)) dut_u (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .slow_internal_osc(osc), .brownout_detect(1'b0),
    .kick_instruction(kick), .halt_instruction(halt), .sleep_mode(sleep),
    .device_reset_q(dev_rst), .pc_sp_reset_q(wake_rst), .pc_zero_q(pc_zero));
  // Count reset pulses and cut a hang short.
  always @(posedge mclk) begin
    cycles++;
    if (dev_rst === 1'b1) rst_cnt++;
    if (wake_rst === 1'b1) wake_cnt++;
    if (cycles == 40000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 8'h0);
    chk(rd & m, e);
  endtask
  task automatic ticks(input int k);
    repeat (k) begin
      osc <= 1'b1;
      repeat (4) @(posedge mclk);
      osc <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask
  // One-cycle strobe of halt or kick.
  task automatic instr(input logic h);
    @(posedge mclk);
    if (h) halt <= 1'b1;
    else kick <= 1'b1;
    @(posedge mclk);
    halt <= 1'b0;
    kick <= 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    rdc(8'h00, 32'hffffffff, 32'h53);
    rdc(8'h08, 32'hffffffff, 32'h55);
    rdc(8'h10, 32'h7, 32'h4);
    rdc(8'h0c, 32'hffffffff, 32'h5a);
    rdc(8'h04, 32'hfffffffb, 32'h0);
    apb(1'b0, 8'h40, 8'h0);
    chk({31'h0, err}, 32'h1);
    $display("test power-on done");
    // Every period code reads back; the two shortest run to overflow.
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 8'h00, {wdg_pkg::KEY_ENABLE, c[2:0]});
      rdc(8'h00, 32'hffffffff, {24'h0, wdg_pkg::KEY_ENABLE, c[2:0]});
      if (c < 2) begin
        instr(1'b0);
        ticks((1 << (8 + 2 * c)) - 1);
        chk(rst_cnt, n);
        ticks(1);
        n++;
        chk(rst_cnt, n);
        rdc(8'h10, 32'h1, 32'h1);
        rdc(8'h00, 32'hffffffff, 32'h53);
      end
    end
    $display("test periods done");
    apb(1'b1, 8'h00, {wdg_pkg::KEY_ENABLE, 3'h0});
    instr(1'b0);
    ticks(200);
    instr(1'b0);
    ticks(200);
    chk(rst_cnt, n);
    instr(1'b1);
    ticks(200);
    chk(rst_cnt, n);
    rdc(8'h10, 32'h3, 32'h2);
    ticks(56);
    n++;
    chk(rst_cnt, n);
    $display("test kick and halt done");
    apb(1'b1, 8'h00, {wdg_pkg::KEY_DISABLE, 3'h0});
    rdc(8'h10, 32'h4, 32'h0);
    instr(1'b1);
    ticks(300);
    chk(rst_cnt, n);
    apb(1'b1, 8'h00, {wdg_pkg::KEY_ENABLE, 3'h0});
    instr(1'b0);
    sleep <= 1'b1;
    ticks(256);
    sleep <= 1'b0;
    chk(wake_cnt, 1);
    chk(rst_cnt, n);
    rdc(8'h00, 32'hffffffff, 32'h50);
    rdc(8'h10, 32'h1, 32'h1);
    $display("test enable and sleep done");
    apb(1'b1, 8'h00, 8'h00);
    ticks(GD + 1);
    n++;
    chk(rst_cnt, n);
    apb(1'b1, 8'h04, 8'hff);
    rdc(8'h04, 32'hfb, 32'h1);
    apb(1'b1, 8'h04, 8'h00);
    rdc(8'h04, 32'hfb, 32'h0);
    apb(1'b1, 8'h08, 8'haa);
    ticks(GD + 1);
    chk(rst_cnt, n);
    rdc(8'h08, 32'hffffffff, 32'haa);
    apb(1'b1, 8'h08, 8'h12);
    ticks(GD + 1);
    n++;
    chk(rst_cnt, n);
    rdc(8'h04, 32'hfb, 32'h8);
    rdc(8'h08, 32'hffffffff, 32'h55);
    apb(1'b1, 8'h0c, 8'h00);
    ticks(GD + 1);
    n++;
    chk(rst_cnt, n);
    rdc(8'h04, 32'hfb, 32'ha);
    $display("test keys and guards done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
